//--- hdl/interp_rate_map.vh
// Register offsets, field positions, reset values and timing counts of the
// interpolation rate and quadrature output conditioner.
// Assumes a 32-bit register port with byte addresses and a 25 MHz mclk.
`ifndef INTERP_RATE_MAP_VH
`define INTERP_RATE_MAP_VH

// ==========================================================================
// Register offsets
`define CFG_ONE_ADDR 8'h00
`define CFG_TWO_ADDR 8'h04
`define BASE_ELEVEN_ADDR 8'h08
`define STATUS_ADDR 8'h0C

// ==========================================================================
// Field positions
`define RATE_SEL_LSB 0
`define RATE_SEL_MSB 4
`define SPACING_LSB 5
`define SPACING_MSB 7
`define HYST_LSB 8
`define HYST_MSB 10
`define EXT_DIV_LSB 0
`define EXT_DIV_MSB 2
`define STAT_RATE_MSB 12
`define STAT_VALID_BIT 13
`define STAT_ABZ_BIT 14
`define STAT_EXP_LSB 16
`define STAT_EXP_MSB 19

// ==========================================================================
// Reset values and basic rates
`define RATE_SEL_RESET 5'h10
`define SPACING_RESET 3'h0
`define HYST_RESET 3'h0
`define EXT_DIV_RESET 3'h0
`define BASE_CODE_00 13'h0FA0
`define BASE_CODE_01 13'h0C80
`define BASE_CODE_10 13'h1000
`define BASE_CODE_11_RESET 13'h0A00
`define MAX_EXP_ANY 4'h7
`define MAX_EXP_FULL 4'hA
// Rates that are only good for counting; A and B are frozen and Z is held low at them.
`define CNT_ONLY_RATE_A 13'h00FA
`define CNT_ONLY_RATE_B 13'h007D
`define CNT_ONLY_RATE_C 13'h0032
`define CNT_ONLY_RATE_D 13'h0019

// ==========================================================================
// Timing: input to output latency in oscillator periods.
`define LATENCY_CYCLES 160

`endif

//--- hdl/hyst_filter.v
// Digital hysteresis on the divided increment stream.
// Assumes single-cycle up and down pulses, never both in one cycle.
`timescale 1ns/100ps
module hyst_filter
(
  input wire mclk,
  input wire reset_n,
  input wire flush,
  input wire [2:0] hyst_amount,
  input wire in_up,
  input wire in_dn,
  output reg out_up,
  output reg out_dn
);

// The lead is kept in [-amount, +amount]; a step leaves only at the edge of
// that band, so at any nonzero amount a dithering input never reaches the outputs.
reg signed [3:0] lead_q;
wire signed [3:0] amount_s = {1'b0, hyst_amount};

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
  begin
    lead_q <= 4'sh0;
    out_up <= 1'b0;
    out_dn <= 1'b0;
  end
  else
  begin
    out_up <= 1'b0;
    out_dn <= 1'b0;
    if (flush)
      lead_q <= 4'sh0;
    else if (in_up)
    begin
      if (lead_q >= amount_s)
        out_up <= 1'b1;
      else
        lead_q <= lead_q + 4'sh1;
    end
    else if (in_dn)
    begin
      if (lead_q <= -amount_s)
        out_dn <= 1'b1;
      else
        lead_q <= lead_q - 4'sh1;
    end
  end
end

endmodule // hyst_filter

//--- hdl/edge_spacer.v
// Minimum edge spacing for the quadrature outputs with a signed backlog.
// Assumes single-cycle step pulses, never both in one cycle.
`timescale 1ns/100ps
module edge_spacer
(
  input wire mclk,
  input wire reset_n,
  input wire flush,
  input wire [2:0] spacing_sel,
  input wire step_up,
  input wire step_dn,
  output wire edge_up,
  output wire edge_dn
);

reg signed [7:0] backlog_q;
reg [7:0] wait_q;
wire ready = (wait_q == 8'h00);
wire [7:0] reload = (8'h01 << spacing_sel) - 8'h01;
wire signed [7:0] step_s = step_up ? 8'sh01 : (step_dn ? -8'sh01 : 8'sh00);
wire signed [7:0] edge_s = edge_up ? 8'sh01 : (edge_dn ? -8'sh01 : 8'sh00);

assign edge_up = ready && (backlog_q > 8'sh00);
assign edge_dn = ready && (backlog_q < 8'sh00);

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
  begin
    backlog_q <= 8'sh00;
    wait_q <= 8'h00;
  end
  else if (flush)
  begin
    backlog_q <= 8'sh00;
    wait_q <= 8'h00;
  end
  else
  begin
    // Saturation is a limitation: steps beyond the backlog range are lost.
    if (!((backlog_q == 8'sh7F && step_up) || (backlog_q == -8'sh80 && step_dn)))
      backlog_q <= backlog_q + step_s - edge_s;
    else
      backlog_q <= backlog_q - edge_s;
    if (edge_up || edge_dn)
      wait_q <= reload;
    else if (!ready)
      wait_q <= wait_q - 8'h01;
  end
end

endmodule // edge_spacer

//--- hdl/interp_rate_abz_conditioner.v
// Interpolation rate selection and A, B, Z output conditioning.
// Assumes the interpolation core delivers one-cycle increment pulses at the
// basic rate, synchronous to mclk, and a one-cycle index pulse.
//
// Contract
// - Interpolation rates from 4 up to 4096 increments per input period are supported.
// - The two upper rate-select bits pick the basic rate 4096, 4000, 3200 or 2560.
// - The basic rate of code 11 resets to 2560 and software may reprogram it.
// - The three lower rate-select bits divide the basic rate by two to their code.
// - A divider setting with a non-whole quotient is invalid.
// - Rates 250, 125, 50 and 25 are counter mode only and their A, B, Z are invalid.
// - The divide exponent is the lower rate-select field plus the extended divider.
// - Exponents 8 to 10 give 16, 8 and 4 on the 4096 base and are invalid elsewhere.
// - Output edges are spaced at least 1 to 128 oscillator periods by a 3-bit code.
// - A 3-bit hysteresis code disables hysteresis at 000 and sets its amount otherwise.
// - With hysteresis on, static inputs never toggle the outputs.
// - With hysteresis on, a reversal is absorbed for up to twice the hysteresis amount in steps.
// - Latency from input to A, B, Z lies between 155 and 187 oscillator periods while no spacing backlog is pending.
// - With hysteresis on, A, B and Z lag by up to the hysteresis amount in increments.
`timescale 1ns/100ps
`include "interp_rate_map.vh"
module interp_rate_abz_conditioner
(
  input wire mclk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire inc_valid,
  input wire inc_dir,
  input wire index_pulse,
  output reg out_a,
  output reg out_b,
  output reg out_z,
  output wire abz_valid
);

// ==========================================================================
// Configuration registers
// Writes land at the strobe edge; no shadow copy is kept, so a change applies at once.
reg [4:0] rate_select_q;
reg [2:0] edge_spacing_sel_q;
reg [2:0] hysteresis_sel_q;
reg [2:0] extended_divider_q;
reg [12:0] base_eleven_q;

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
  begin
    rate_select_q <= `RATE_SEL_RESET;
    edge_spacing_sel_q <= `SPACING_RESET;
    hysteresis_sel_q <= `HYST_RESET;
    extended_divider_q <= `EXT_DIV_RESET;
    base_eleven_q <= `BASE_CODE_11_RESET;
  end
  else if (reg_wr)
  begin
    if (reg_addr == `CFG_ONE_ADDR)
    begin
      rate_select_q <= reg_wdata[`RATE_SEL_MSB:`RATE_SEL_LSB];
      edge_spacing_sel_q <= reg_wdata[`SPACING_MSB:`SPACING_LSB];
      hysteresis_sel_q <= reg_wdata[`HYST_MSB:`HYST_LSB];
    end
    else if (reg_addr == `CFG_TWO_ADDR)
      extended_divider_q <= reg_wdata[`EXT_DIV_MSB:`EXT_DIV_LSB];
    // Only thirteen bits of the base word are kept; the rest read as zero.
    // user may reprogram
    else if (reg_addr == `BASE_ELEVEN_ADDR)
      base_eleven_q <= reg_wdata[12:0];
  end
end

// ==========================================================================
// Rate decode
wire [1:0] base_code = rate_select_q[4:3];
wire [3:0] divide_exponent = {1'b0, rate_select_q[2:0]} + {1'b0, extended_divider_q};

reg [12:0] base_rate;
reg rate_valid;
reg counter_only;
reg [12:0] exp_mask;
reg [12:0] rate_quot;

always @*
begin
  if (base_code == 2'b10)
    base_rate = `BASE_CODE_10;
  else if (base_code == 2'b00)
    base_rate = `BASE_CODE_00;
  else if (base_code == 2'b01)
    base_rate = `BASE_CODE_01;
  else
    base_rate = base_eleven_q;
  exp_mask = (13'h0001 << divide_exponent) - 13'h0001;
  rate_valid = ((base_rate & exp_mask) == 13'h0000) && (base_rate != 13'h0000);
  // The 4096 base alone has enough factors of two for the extended divider.
  // large exponents need 4096
  if (divide_exponent > `MAX_EXP_FULL)
    rate_valid = 1'b0;
  else if ((divide_exponent > `MAX_EXP_ANY) && (base_code != 2'b10))
    rate_valid = 1'b0;
  // The test looks at the resulting rate rather than at the code, so a reprogrammed
  // code-11 base that lands on one of these rates is caught as well.
  rate_quot = base_rate >> divide_exponent;
  counter_only = rate_valid && ((rate_quot == `CNT_ONLY_RATE_A)
    || (rate_quot == `CNT_ONLY_RATE_B)
    || (rate_quot == `CNT_ONLY_RATE_C)
    || (rate_quot == `CNT_ONLY_RATE_D));
end

// rate is base over power of two
wire [12:0] interp_rate = rate_valid ? rate_quot : 13'h0000;

// The flag is combinational, so it already reflects a write in the cycle after its strobe.
// suppress when invalid
assign abz_valid = rate_valid && !counter_only;

// A change of rate select, extended divider, hysteresis or spacing bit zero restarts the conditioning chain from a clean state.
// Dropping the partial divider count and any steps still in the spacing backlog is preferred over letting counts made
// under the old divider or hysteresis leak into the new setting.
// Spacing bits above bit zero are left out on purpose: they only stretch the next gap.
reg [12:0] last_cfg_q;
wire [12:0] cur_cfg = {rate_select_q, extended_divider_q, hysteresis_sel_q, abz_valid,
  edge_spacing_sel_q[0]};
wire flush = !abz_valid || (cur_cfg != last_cfg_q);

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
    last_cfg_q <= 13'h0000;
  else
    last_cfg_q <= cur_cfg;
end

// ==========================================================================
// Register read port
// Unmapped addresses read as zero, so probing software sees no stray bits.
always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
    reg_rdata <= 32'h0000_0000;
  else if (reg_rd)
  begin
    reg_rdata <= 32'h0000_0000;
    if (reg_addr == `CFG_ONE_ADDR)
      reg_rdata[`HYST_MSB:0] <= {hysteresis_sel_q, edge_spacing_sel_q, rate_select_q};
    else if (reg_addr == `CFG_TWO_ADDR)
      reg_rdata[`EXT_DIV_MSB:0] <= extended_divider_q;
    else if (reg_addr == `BASE_ELEVEN_ADDR)
      reg_rdata[12:0] <= base_eleven_q;
    else if (reg_addr == `STATUS_ADDR)
    begin
      reg_rdata[`STAT_RATE_MSB:0] <= interp_rate;
      reg_rdata[`STAT_VALID_BIT] <= rate_valid;
      reg_rdata[`STAT_ABZ_BIT] <= abz_valid;
      reg_rdata[`STAT_EXP_MSB:`STAT_EXP_LSB] <= divide_exponent;
    end
  end
end

// ==========================================================================
// Latency line
// A shift register costs flops but never drops a pulse, unlike a timestamp queue.
// fixed pipeline delay
// The remaining stages add a few cycles, keeping the sum inside the window
// while no spacing backlog is pending.
localparam LAT = `LATENCY_CYCLES - 4;
reg [3*LAT-1:0] pipe_q;
wire [2:0] pipe_out = pipe_q[3*LAT-1:3*LAT-3];

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
    pipe_q <= {3*LAT{1'b0}};
  else
    pipe_q <= {pipe_q[3*LAT-4:0], inc_valid, inc_dir, index_pulse};
end

wire d_inc = pipe_out[2];
wire d_up = pipe_out[1];
wire d_index = pipe_out[0];

// ==========================================================================
// Divider
// Ten bits cover the largest valid exponent; wrapping is harmless because only the
// low bits selected by the mask are ever compared.
// divide by counting fine steps
reg [9:0] fine_q;
reg div_up_q;
reg div_dn_q;
wire [9:0] low_mask = exp_mask[9:0];

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
  begin
    fine_q <= 10'h000;
    div_up_q <= 1'b0;
    div_dn_q <= 1'b0;
  end
  else
  begin
    div_up_q <= 1'b0;
    div_dn_q <= 1'b0;
    if (flush)
      fine_q <= 10'h000;
    else if (d_inc && d_up)
    begin
      fine_q <= fine_q + 10'h001;
      div_up_q <= ((fine_q & low_mask) == low_mask);
    end
    // Down steps are recognised at the all-zero end so both directions share one boundary.
    else if (d_inc)
    begin
      fine_q <= fine_q - 10'h001;
      div_dn_q <= ((fine_q & low_mask) == 10'h000);
    end
  end
end

// ==========================================================================
// Hysteresis and spacing
wire hy_up;
wire hy_dn;
wire edge_up;
wire edge_dn;

// Hysteresis sits ahead of the spacer, so absorbed steps never take a spacing slot.
// code zero disables
hyst_filter u_hyst
(
  .mclk(mclk),
  .reset_n(reset_n),
  .flush(flush),
  .hyst_amount(hysteresis_sel_q),
  .in_up(div_up_q),
  .in_dn(div_dn_q),
  .out_up(hy_up),
  .out_dn(hy_dn)
);

edge_spacer u_spacer
(
  .mclk(mclk),
  .reset_n(reset_n),
  .flush(flush),
  .spacing_sel(edge_spacing_sel_q),
  .step_up(hy_up),
  .step_dn(hy_dn),
  .edge_up(edge_up),
  .edge_dn(edge_dn)
);

// ==========================================================================
// Quadrature and index outputs
// A two-bit phase decoded in Gray order guarantees that A and B never move together.
reg [1:0] phase_q;
reg index_armed_q;
wire [1:0] phase_d = edge_up ? phase_q + 2'b01 : (edge_dn ? phase_q - 2'b01 : phase_q);

always @(posedge mclk or negedge reset_n)
begin
  if (!reset_n)
  begin
    phase_q <= 2'b00;
    index_armed_q <= 1'b0;
    out_a <= 1'b0;
    out_b <= 1'b0;
    out_z <= 1'b0;
  end
  else if (flush)
  begin
    // Holding A and B rather than parking them keeps the far counter's position intact.
    // outputs frozen
    index_armed_q <= 1'b0;
    out_z <= 1'b0;
  end
  else
  begin
    phase_q <= phase_d;
    out_a <= phase_d[1];
    out_b <= phase_d[1] ^ phase_d[0];
    // The index is one increment wide, riding on the edge after its arrival.
    if (edge_up || edge_dn)
    begin
      out_z <= index_armed_q;
      index_armed_q <= d_index;
    end
    else if (d_index)
      index_armed_q <= 1'b1;
  end
end

endmodule // interp_rate_abz_conditioner

//--- sim/abz_checker_asserts.sv
// Checker for the register port and the A, B, Z outputs of the conditioner.
// Assumes binding to the top module; the configuration is tracked from port writes.
`timescale 1ns/100ps
module abz_checker
(
  input wire mclk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire inc_valid,
  input wire inc_dir,
  input wire index_pulse,
  input wire out_a,
  input wire out_b,
  input wire out_z,
  input wire abz_valid
);
  // ==========================================================================
  // Shadow configuration and edge timers
  reg [10:0] cfg_q;
  reg [2:0] ext_q;
  reg [7:0] gap_q;
  reg [8:0] quiet_q;
  reg a_q;
  reg b_q;
  wire edge_ab = (out_a != a_q) || (out_b != b_q);
  // Beyond 200 quiet cycles the latency line is empty, so nothing may still move.
  wire hyst_idle = quiet_q > 9'h0C8 && cfg_q[10:8] != 3'h0 && cfg_q[7:5] == 3'h0;
  always @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      cfg_q <= 11'h010;
      ext_q <= 3'h0;
      gap_q <= 8'hFF;
      quiet_q <= 9'h000;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h00)
        cfg_q <= reg_wdata[10:0];
      if (reg_wr && reg_addr == 8'h04)
        ext_q <= reg_wdata[2:0];
      gap_q <= edge_ab ? 8'h01 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
      quiet_q <= inc_valid ? 9'h000 : (quiet_q == 9'h1FF ? quiet_q : quiet_q + 9'h001);
      a_q <= out_a;
      b_q <= out_b;
    end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence step_s;
    $changed(out_a) || $changed(out_b);
  endsequence
  sequence plain_inc_s;
    inc_valid && cfg_q == 11'h010 && ext_q == 3'h0;
  endsequence
  AST_QUAD_ONE_PHASE: assert property (!($changed(out_a) && $changed(out_b)))
    else $error("A and B changed in the same cycle");
  AST_EDGE_GAP: assert property (edge_ab |-> gap_q >= (8'h01 << cfg_q[7:5]))
    else $error("output edges closer than the spacing setting");
  AST_LATENCY: assert property (plain_inc_s |-> ##[155:187] step_s)
    else $error("no output edge inside the latency window");
  AST_STATIC_HYST: assert property (hyst_idle |-> !edge_ab)
    else $error("output moved with static input and hysteresis on");
  AST_NO_Z_INVALID: assert property (!abz_valid |=> !out_z)
    else $error("index output high while outputs are invalid");
  AST_HOLD_INVALID: assert property (!abz_valid && !$past(abz_valid) |-> $stable({out_a, out_b}))
    else $error("quadrature moved while outputs are invalid");
  AST_INVALID_CFG: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[4:2] == 3'h1
    && ext_q == 3'h0 |=> !abz_valid)
    else $error("outputs still valid for a counter-only or invalid rate");
  AST_EXPONENT: assert property (reg_rd && reg_addr == 8'h0C
    |=> reg_rdata[19:16] == {1'b0, cfg_q[2:0]} + {1'b0, ext_q})
    else $error("divide exponent is not the sum of both fields");
  AST_RATE_4096: assert property (reg_rd && reg_addr == 8'h0C && cfg_q[4:3] == 2'h2
    && ext_q == 3'h0 |=> reg_rdata[12:0] == (13'h1000 >> cfg_q[2:0]))
    else $error("rate on the 4096 base is wrong");
endmodule // abz_checker
bind interp_rate_abz_conditioner abz_checker u_abz_checker (.mclk(mclk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .inc_valid(inc_valid), .inc_dir(inc_dir), .index_pulse(index_pulse),
  .out_a(out_a), .out_b(out_b), .out_z(out_z), .abz_valid(abz_valid));

//--- sim/quad_counter.sv
// Far-end quadrature up/down counter with quadruple evaluation.
// Assumes A, B, Z are sampled on mclk; gap_clr restarts the edge-gap record.
`timescale 1ns/100ps
module quad_counter
(
  input wire mclk,
  input wire reset_n,
  input wire a,
  input wire b,
  input wire z,
  input wire gap_clr,
  output reg signed [15:0] count,
  output reg [7:0] z_cnt,
  output reg [7:0] min_gap,
  output reg bad
);
  // ==========================================================================
  // Counting
  reg a_q;
  reg b_q;
  reg z_q;
  reg [7:0] gap_q;
  always @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      count <= 16'sh0000;
      z_cnt <= 8'h00;
      min_gap <= 8'hFF;
      bad <= 1'b0;
      a_q <= 1'b0;
      b_q <= 1'b0;
      z_q <= 1'b0;
      gap_q <= 8'hFF;
    end
    else
    begin
      a_q <= a;
      b_q <= b;
      z_q <= z;
      if (z && !z_q)
        z_cnt <= z_cnt + 8'h01;
      if (gap_clr)
        min_gap <= 8'hFF;
      if ((a != a_q) || (b != b_q))
      begin
        gap_q <= 8'h01;
        if (gap_q < min_gap && !gap_clr)
          min_gap <= gap_q;
        // A real counter loses the step when both lines move at once.
        if ((a != a_q) && (b != b_q))
          bad <= 1'b1;
        else if ((b != b_q) ? (b != a_q) : (a == b_q))
          count <= count + 16'sh0001;
        else
          count <= count - 16'sh0001;
      end
      else if (gap_q != 8'hFF)
        gap_q <= gap_q + 8'h01;
    end
endmodule // quad_counter

//--- sim/tb_top.sv
// Self-checking bench for the rate conditioner and its A, B, Z outputs.
// Assumes the quadrature counter model on the outputs and the bound checker.
`timescale 1ns/100ps
module tb_top;
  reg mclk;
  reg reset_n;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  wire [31:0] reg_rdata;
  reg inc_valid;
  reg inc_dir;
  reg index_pulse;
  reg gap_clr;
  wire out_a;
  wire out_b;
  wire out_z;
  wire abz_valid;
  wire signed [15:0] count;
  wire [7:0] z_cnt;
  wire [7:0] min_gap;
  wire bad;
  integer n_mismatch;
  integer n_tests;
  integer k;
  integer lat;
  reg [15:0] ex;
  reg [12:0] b11;
  reg [1:0] ab;
  interp_rate_abz_conditioner DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .inc_valid(inc_valid), .inc_dir(inc_dir), .index_pulse(index_pulse), .out_a(out_a),
    .out_b(out_b), .out_z(out_z), .abz_valid(abz_valid));
  quad_counter far_end (.mclk(mclk), .reset_n(reset_n), .a(out_a), .b(out_b), .z(out_z),
    .gap_clr(gap_clr), .count(count), .z_cnt(z_cnt), .min_gap(min_gap), .bad(bad));
  // ==========================================================================
  // Clock, tasks and the expected status word
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task cmp(input [63:0] name, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s expected %h seen %h", name, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      cmp("rdata", e, reg_rdata);
    end
  endtask
  task inc(input d, input integer n);
    begin
      @(posedge mclk);
      inc_valid <= 1'b1;
      inc_dir <= d;
      repeat (n) @(posedge mclk);
      inc_valid <= 1'b0;
    end
  endtask
  task chk_count(input integer wait_cycles);
    begin
      repeat (wait_cycles) @(posedge mclk);
      #1;
      cmp("count", {16'h0000, ex}, {16'h0000, count});
    end
  endtask
  task complete_run;
    begin
      if (n_mismatch == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  function [31:0] stat_exp(input [4:0] s, input [2:0] x, input [12:0] b);
    reg [12:0] base;
    reg [12:0] r;
    reg [3:0] e;
    reg v;
    reg c;
    begin
      base = (s[4:3] == 2'h2) ? 13'h1000 : (s[4:3] == 2'h0) ? 13'h0FA0 :
        (s[4:3] == 2'h1) ? 13'h0C80 : b;
      e = {1'b0, s[2:0]} + {1'b0, x};
      r = base >> e;
      v = e <= 4'hA && (base & ((13'h0001 << e) - 13'h0001)) == 13'h0000
        && (e <= 4'h7 || s[4:3] == 2'h2) && base != 13'h0000;
      c = r == 13'h00FA || r == 13'h007D || r == 13'h0032 || r == 13'h0019;
      stat_exp = {12'h000, e, 1'b0, v && !c, v, v ? r : 13'h0000};
    end
  endfunction
  // Watchdog sized well above the roughly 4700 cycles the sequence needs.
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    ex = 16'h0000;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    inc_valid = 1'b0;
    inc_dir = 1'b0;
    index_pulse = 1'b0;
    gap_clr = 1'b0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    rd(8'h00, 32'h0000_0010);
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_0A00);
    rd(8'h0C, 32'h0000_7000);
    rd(8'h10, 32'h0000_0000);
    for (k = 0; k < 256; k = k + 1)
    begin
      b11 = k[7] ? 13'h0960 : 13'h0A00;
      wr(8'h08, {19'h00000, b11});
      wr(8'h04, {30'h0000_0000, k[6:5]});
      wr(8'h00, {27'h000_0000, k[4:0]});
      rd(8'h0C, stat_exp(k[4:0], {1'b0, k[6:5]}, b11));
    end
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0012);
    inc(1'b1, 20);
    ex = ex + 16'h0005;
    chk_count(250);
    inc(1'b0, 8);
    ex = ex - 16'h0002;
    chk_count(250);
    wr(8'h00, 32'h0000_0010);
    repeat (10) @(posedge mclk);
    @(posedge mclk);
    inc_valid <= 1'b1;
    inc_dir <= 1'b1;
    index_pulse <= 1'b1;
    @(posedge mclk);
    inc_valid <= 1'b0;
    index_pulse <= 1'b0;
    lat = 0;
    ab = {out_a, out_b};
    while ({out_a, out_b} === ab && lat < 300)
    begin
      @(posedge mclk);
      #1;
      lat = lat + 1;
    end
    cmp("latency", 32'h0000_0001, {31'h0, lat >= 155 && lat <= 187});
    cmp("index", 32'h0000_0001, {31'h0, out_z});
    inc(1'b1, 1);
    ex = ex + 16'h0002;
    chk_count(250);
    cmp("zcount", 32'h0000_0001, {24'h00_0000, z_cnt});
    wr(8'h00, 32'h0000_0070);
    @(posedge mclk);
    gap_clr <= 1'b1;
    @(posedge mclk);
    gap_clr <= 1'b0;
    inc(1'b1, 10);
    ex = ex + 16'h000A;
    chk_count(400);
    cmp("gap", 32'h0000_0001, {31'h0, min_gap >= 8'h08});
    wr(8'h00, 32'h0000_0110);
    inc(1'b1, 3);
    ex = ex + 16'h0002;
    chk_count(250);
    inc(1'b0, 3);
    ex = ex - 16'h0001;
    chk_count(250);
    inc(1'b1, 1);
    chk_count(250);
    inc(1'b0, 1);
    chk_count(250);
    wr(8'h00, 32'h0000_0006);
    #1;
    cmp("abzvalid", 32'h0000_0000, {31'h0, abz_valid});
    inc(1'b1, 8);
    chk_count(250);
    cmp("index", 32'h0000_0000, {31'h0, out_z});
    wr(8'h00, 32'h0000_0004);
    #1;
    cmp("abzvalid", 32'h0000_0000, {31'h0, abz_valid});
    cmp("phase", 32'h0000_0000, {31'h0, bad});
    complete_run;
  end
endmodule // tb_top
